/* File: stcb_baud_gen.sv */
// baud tick generator: one tick every pre * (divisor + 1) clocks
// assumes clear is pulsed when a frame starts, to align bit edges
module stcb_baud_gen (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic [6:0] pre_i,
  input wire logic [7:0] divisor_i,
  output logic tick_o
);

  logic [6:0] pre_cnt_reg;
  logic [7:0] div_cnt_reg;
  wire pre_wrap = (pre_cnt_reg == (pre_i - 7'h01));
  wire div_wrap = (div_cnt_reg == divisor_i);

  assign tick_o = pre_wrap && div_wrap && !clear_i;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pre_cnt_reg <= 7'h00;
      div_cnt_reg <= 8'h00;
    end else if (clear_i || pre_wrap) begin
      pre_cnt_reg <= 7'h00;
      if (clear_i || div_wrap) begin
        div_cnt_reg <= 8'h00;
      end else begin
        div_cnt_reg <= div_cnt_reg + 8'h01;
      end
    end else begin
      pre_cnt_reg <= pre_cnt_reg + 7'h01;
    end
  end

endmodule

/* File: stcb_link_partner.sv */
// remote serial node: async receiver, sync clock source and sync sink
// assumes tx_i and the link clock are sampled on the core clock
module stcb_link_partner (
  input wire logic core_clk_i,
  input wire logic tx_i,
  input wire logic [15:0] bit_len_i,
  input wire logic nine_i,
  input wire logic clk_oe_i,
  input wire logic clk_in_i,
  input wire logic slave_go_i,
  output logic link_clk_o,
  output logic [8:0] rx_data_o,
  output logic stop_o,
  output int rx_count_o,
  output int low_len_o,
  output logic [8:0] sync_sh_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int low_run = 0;
  logic lk_q = 1'b0;
  wire logic lk = clk_oe_i ? clk_in_i : link_clk_o;
  initial begin
    link_clk_o = 1'b0;
    rx_data_o = 9'h000;
    stop_o = 1'b1;
    rx_count_o = 0;
    low_len_o = 0;
    sync_sh_o = 9'h000;
  end
  // sync sink: lsb first, taken at each rising link clock
  always @(posedge core_clk_i) begin
    lk_q <= lk;
    if (lk && !lk_q) sync_sh_o <= {tx_i, sync_sh_o[8:1]};
    low_run <= tx_i ? 0 : low_run + 1;
    if (tx_i && low_run != 0) low_len_o <= low_run;
  end
  // async receiver, mid-bit sampling
  always begin
    @(negedge tx_i);
    rx_data_o = 9'h000;
    repeat (bit_len_i / 2) @(posedge core_clk_i);
    for (int i = 0; i < (nine_i ? 9 : 8); i++) begin
      repeat (bit_len_i) @(posedge core_clk_i);
      rx_data_o[i] = tx_i;
    end
    repeat (bit_len_i) @(posedge core_clk_i);
    stop_o = tx_i;
    rx_count_o++;
  end
  // slave clock: eight pulses per frame, still low otherwise
  always @(posedge slave_go_i) begin
    repeat (8) begin
      repeat (4) @(posedge core_clk_i);
      link_clk_o <= 1'b1;
      repeat (4) @(posedge core_clk_i);
      link_clk_o <= 1'b0;
    end
  end
endmodule

/* File: stcb_pkg.sv */
// shared constants and types for the serial transmit control block
// assumes a 50 MHz core clock and an AXI4-Lite register master
package stcb_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_TSC = 8'h00;
  localparam logic [7:0] OFF_DIV = 8'h04;
  localparam logic [7:0] OFF_TXDATA = 8'h08;
  localparam logic [7:0] OFF_RXCTL = 8'h0C;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFF_IRQ_EN = 8'h14;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h18;

  localparam logic [7:0] TSC_RESET = 8'h02;
  localparam logic [7:0] DIV_RESET = 8'h00;
  localparam logic [1:0] RXCTL_RESET = 2'h0;
  localparam logic [1:0] IRQ_RESET = 2'h0;

  localparam int unsigned RXCTL_CONTINUOUS_RECEIVE_ENABLE_BIT = 0;
  localparam int unsigned RXCTL_ADDR_BIT = 1;
  localparam int unsigned IRQ_CHAR_DONE = 0;
  localparam int unsigned IRQ_BREAK_DONE = 1;
  localparam int unsigned TXDATA_FULL_BIT = 8;

  // ----------------------------------------------------------------
  // baud prescalers and frame lengths
  // ----------------------------------------------------------------
  localparam logic [6:0] PRE_ASYNC_LO = 7'h40;
  localparam logic [6:0] PRE_ASYNC_HI = 7'h10;
  localparam logic [6:0] PRE_SYNC_HALF = 7'h02;

  localparam int unsigned SHIFT_W = 14;
  localparam logic [3:0] FRAME_ASYNC_8 = 4'hA;
  localparam logic [3:0] FRAME_ASYNC_9 = 4'hB;
  localparam logic [3:0] FRAME_BREAK = 4'hE;
  localparam logic [3:0] FRAME_SYNC_8 = 4'h8;
  localparam logic [3:0] FRAME_SYNC_9 = 4'h9;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic clock_source_select;
    logic nine_bit_transmit_enable;
    logic transmitter_enable;
    logic sync_mode_select;
    logic break_send_request;
    logic high_speed_baud_select;
    logic shift_register_empty;
    logic ninth_transmit_bit;
  } stcb_ctrl_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_SHIFT = 1'b1
  } stcb_state_t;

  function automatic logic word_hit(input logic [7:0] addr,
                                    input logic [7:0] off);
    word_hit = (addr[7:2] == off[7:2]);
  endfunction

endpackage

/* File: stcb_top.sv */
// serial transmitter with control/status, baud divisor and interrupts
// assumes an AXI4-Lite master and synchronous link pin inputs
//
// How it works
// (R1) in sync mode clock select one makes us master driving link clock
// (R2) mode bit one selects synchronous, zero asynchronous operation
// (R3) async: high speed bit picks x16, else x64; ignored in sync
// (R4) ninth transmit bit supplies the ninth data bit when nine-bit
// (R5) async low speed: rate = clock / (64 * (divisor + 1))
// (R6) async high speed: rate = clock / (16 * (divisor + 1))
// (R7) software clears continuous receive enable after any receive error
// (R8) software clears address detect enable once addressed
// (R9) nine-bit enable sends nine bits; enable gates transmission and pin
// (R10) break request sends break, self-clears; empty flag shows shifter; code sends the break in async mode only, on the next load
module stcb_top (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic tx_o,
  output logic tx_oe_o,
  input wire logic link_clk_i,
  output logic link_clk_o,
  output logic link_clk_oe_o,
  output logic continuous_receive_enable_o,
  output logic address_detect_enable_o,
  output logic irq_o
);

  default clocking chk_clk @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  stcb_pkg::stcb_ctrl_t ctrl_reg;
  stcb_pkg::stcb_state_t state_reg;
  logic [7:0] baud_divisor_reg;
  logic [7:0] tx_hold_reg;
  logic hold_full_reg;
  logic [1:0] rx_ctl_reg;
  logic [1:0] irq_stat_reg;
  logic [1:0] irq_en_reg;
  logic [stcb_pkg::SHIFT_W-1:0] transmit_shift_register;
  logic [3:0] bit_cnt_reg;
  logic is_break_reg;
  logic clk_out_reg;
  logic link_clk_prev_reg;
  logic aw_hold_reg;
  logic w_hold_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [1:0] bresp_reg;
  logic bvalid_reg;
  logic rvalid_reg;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
  wire wr_lane0 = do_write && wstrb_reg[0];
  wire wr_tsc = wr_lane0 && stcb_pkg::word_hit(aw_addr_reg,
                                               stcb_pkg::OFF_TSC);
  wire wr_div = wr_lane0 && stcb_pkg::word_hit(aw_addr_reg,
                                               stcb_pkg::OFF_DIV);
  wire wr_data = wr_lane0 && stcb_pkg::word_hit(aw_addr_reg,
                                                stcb_pkg::OFF_TXDATA);
  wire wr_rxctl = wr_lane0 && stcb_pkg::word_hit(aw_addr_reg,
                                                 stcb_pkg::OFF_RXCTL);
  wire wr_irq_en = wr_lane0 && stcb_pkg::word_hit(aw_addr_reg,
                                                  stcb_pkg::OFF_IRQ_EN);
  wire wr_irq_clr = wr_lane0 && stcb_pkg::word_hit(aw_addr_reg,
                                                   stcb_pkg::OFF_IRQ_CLR);
  wire wr_known = stcb_pkg::word_hit(aw_addr_reg, stcb_pkg::OFF_TSC)
    || stcb_pkg::word_hit(aw_addr_reg, stcb_pkg::OFF_DIV)
    || stcb_pkg::word_hit(aw_addr_reg, stcb_pkg::OFF_TXDATA)
    || stcb_pkg::word_hit(aw_addr_reg, stcb_pkg::OFF_RXCTL)
    || stcb_pkg::word_hit(aw_addr_reg, stcb_pkg::OFF_IRQ_EN)
    || stcb_pkg::word_hit(aw_addr_reg, stcb_pkg::OFF_IRQ_CLR);
  wire rd_take = s_axi_arvalid && !rvalid_reg;

  // ----------------------------------------------------------------
  // transmit control
  // ----------------------------------------------------------------
  wire sync_mode = ctrl_reg.sync_mode_select;
  wire busy = (state_reg == stcb_pkg::ST_SHIFT);
  wire shifter_empty = !busy; // R10
  wire [6:0] pre_sel = sync_mode ? stcb_pkg::PRE_SYNC_HALF : // R2
    (ctrl_reg.high_speed_baud_select ? stcb_pkg::PRE_ASYNC_HI : // R3 R6
     stcb_pkg::PRE_ASYNC_LO); // R5
  wire load = !busy && hold_full_reg && ctrl_reg.transmitter_enable; // R9
  wire load_break = !sync_mode && ctrl_reg.break_send_request; // R10
  wire baud_tick;
  wire sync_master = sync_mode && ctrl_reg.clock_source_select; // R1
  wire link_fall = link_clk_prev_reg && !link_clk_i;
  wire step = sync_mode
    ? (sync_master ? (baud_tick && clk_out_reg) : link_fall) // R1
    : baud_tick;
  wire last_step = busy && step && (bit_cnt_reg == 4'h1);
  wire char_done = last_step && !is_break_reg;
  wire break_done = last_step && is_break_reg;
  wire [1:0] irq_events = {break_done, char_done};
  wire abort = busy && !ctrl_reg.transmitter_enable; // R9

  wire [stcb_pkg::SHIFT_W-1:0] frame_async =
    ctrl_reg.nine_bit_transmit_enable
    ? {4'hF, ctrl_reg.ninth_transmit_bit, tx_hold_reg, 1'b0} // R4 R9
    : {5'h1F, tx_hold_reg, 1'b0};
  wire [stcb_pkg::SHIFT_W-1:0] frame_sync =
    ctrl_reg.nine_bit_transmit_enable
    ? {5'h1F, ctrl_reg.ninth_transmit_bit, tx_hold_reg} // R4 R9
    : {6'h3F, tx_hold_reg};
  wire [stcb_pkg::SHIFT_W-1:0] frame_break = 14'h2000;
  wire [stcb_pkg::SHIFT_W-1:0] frame_sel = sync_mode ? frame_sync
    : (load_break ? frame_break : frame_async);
  wire [3:0] len_sel = sync_mode
    ? (ctrl_reg.nine_bit_transmit_enable ? stcb_pkg::FRAME_SYNC_9
       : stcb_pkg::FRAME_SYNC_8)
    : (load_break ? stcb_pkg::FRAME_BREAK
       : (ctrl_reg.nine_bit_transmit_enable ? stcb_pkg::FRAME_ASYNC_9
          : stcb_pkg::FRAME_ASYNC_8));

  stcb_baud_gen u_baud (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .clear_i(load),
    .pre_i(pre_sel),
    .divisor_i(baud_divisor_reg),
    .tick_o(baud_tick)
  );

  // ----------------------------------------------------------------
  // register read data
  // ----------------------------------------------------------------
  wire [7:0] tsc_view = {ctrl_reg[7:2], shifter_empty, // R10
                         ctrl_reg.ninth_transmit_bit};
  wire [31:0] rd_mux =
    stcb_pkg::word_hit(s_axi_araddr, stcb_pkg::OFF_TSC) ? {24'h0, tsc_view}
    : stcb_pkg::word_hit(s_axi_araddr, stcb_pkg::OFF_DIV)
      ? {24'h0, baud_divisor_reg}
    : stcb_pkg::word_hit(s_axi_araddr, stcb_pkg::OFF_TXDATA)
      ? {23'h0, hold_full_reg, tx_hold_reg}
    : stcb_pkg::word_hit(s_axi_araddr, stcb_pkg::OFF_RXCTL)
      ? {30'h0, rx_ctl_reg}
    : stcb_pkg::word_hit(s_axi_araddr, stcb_pkg::OFF_IRQ_STAT)
      ? {30'h0, irq_stat_reg}
    : stcb_pkg::word_hit(s_axi_araddr, stcb_pkg::OFF_IRQ_EN)
      ? {30'h0, irq_en_reg}
    : 32'h0000_0000;
  wire rd_known = stcb_pkg::word_hit(s_axi_araddr, stcb_pkg::OFF_TSC)
    || stcb_pkg::word_hit(s_axi_araddr, stcb_pkg::OFF_DIV)
    || stcb_pkg::word_hit(s_axi_araddr, stcb_pkg::OFF_TXDATA)
    || stcb_pkg::word_hit(s_axi_araddr, stcb_pkg::OFF_RXCTL)
    || stcb_pkg::word_hit(s_axi_araddr, stcb_pkg::OFF_IRQ_STAT)
    || stcb_pkg::word_hit(s_axi_araddr, stcb_pkg::OFF_IRQ_EN);

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready = !w_hold_reg && !bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign tx_o = busy ? transmit_shift_register[0] : 1'b1;
  assign tx_oe_o = ctrl_reg.transmitter_enable; // R9
  assign link_clk_o = clk_out_reg;
  assign link_clk_oe_o = sync_master && ctrl_reg.transmitter_enable; // R1
  assign continuous_receive_enable_o = rx_ctl_reg[stcb_pkg::RXCTL_CONTINUOUS_RECEIVE_ENABLE_BIT];
  assign address_detect_enable_o = rx_ctl_reg[stcb_pkg::RXCTL_ADDR_BIT];
  assign irq_o = |(irq_stat_reg & irq_en_reg);

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= stcb_pkg::RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= stcb_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_known ? stcb_pkg::RESP_OKAY : stcb_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
      if (rd_take) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_mux;
        rresp_reg <= rd_known ? stcb_pkg::RESP_OKAY : stcb_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_reg <= stcb_pkg::TSC_RESET;
      baud_divisor_reg <= stcb_pkg::DIV_RESET;
      tx_hold_reg <= 8'h00;
      hold_full_reg <= 1'b0;
      rx_ctl_reg <= stcb_pkg::RXCTL_RESET;
      irq_en_reg <= stcb_pkg::IRQ_RESET;
      irq_stat_reg <= stcb_pkg::IRQ_RESET;
    end else begin
      if (wr_tsc) begin
        ctrl_reg <= wdata_reg[7:0];
      end else if (break_done) begin
        ctrl_reg.break_send_request <= 1'b0; // R10
      end
      if (wr_div) begin
        baud_divisor_reg <= wdata_reg[7:0];
      end
      if (wr_data && !hold_full_reg) begin
        tx_hold_reg <= wdata_reg[7:0];
      end
      hold_full_reg <= (wr_data || hold_full_reg) && !load;
      if (wr_rxctl) begin
        rx_ctl_reg <= wdata_reg[1:0]; // R7 R8
      end
      if (wr_irq_en) begin
        irq_en_reg <= wdata_reg[1:0];
      end
      irq_stat_reg <= (irq_stat_reg
        & ~(wr_irq_clr ? wdata_reg[1:0] : 2'h0)) | irq_events;
    end
  end

  // ----------------------------------------------------------------
  // shifter
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= stcb_pkg::ST_IDLE;
      transmit_shift_register <= 14'h3FFF;
      bit_cnt_reg <= 4'h0;
      is_break_reg <= 1'b0;
      clk_out_reg <= 1'b0;
      link_clk_prev_reg <= 1'b0;
    end else begin
      link_clk_prev_reg <= link_clk_i;
      unique case (state_reg)
        stcb_pkg::ST_IDLE: begin
          clk_out_reg <= 1'b0;
          if (load) begin
            state_reg <= stcb_pkg::ST_SHIFT;
            transmit_shift_register <= frame_sel;
            bit_cnt_reg <= len_sel;
            is_break_reg <= load_break; // R10
          end
        end
        stcb_pkg::ST_SHIFT: begin
          if (abort || last_step) begin
            state_reg <= stcb_pkg::ST_IDLE;
            clk_out_reg <= 1'b0;
          end else if (step) begin
            transmit_shift_register <= {1'b1,
              transmit_shift_register[stcb_pkg::SHIFT_W-1:1]};
            bit_cnt_reg <= bit_cnt_reg - 4'h1;
            clk_out_reg <= 1'b0;
          end else if (sync_master && baud_tick) begin
            clk_out_reg <= 1'b1; // R1
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [15:0] gap_cnt_reg;
  logic gap_ok_reg;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      gap_cnt_reg <= 16'h0001;
      gap_ok_reg <= 1'b0;
    end else if (load || wr_div || wr_tsc) begin
      gap_cnt_reg <= 16'h0001;
      gap_ok_reg <= 1'b0;
    end else if (baud_tick) begin
      gap_cnt_reg <= 16'h0001;
      gap_ok_reg <= 1'b1;
    end else begin
      gap_cnt_reg <= gap_cnt_reg + 16'h0001;
    end
  end

  sequence s_load_async9;
    load && !sync_mode && !load_break && ctrl_reg.nine_bit_transmit_enable;
  endsequence
  sequence s_break_run;
    load && load_break ##1 busy [*8];
  endsequence

  chk_lo_speed_gap: assert property ( // R5
    baud_tick && gap_ok_reg && !sync_mode && !ctrl_reg.high_speed_baud_select
    |-> gap_cnt_reg == 16'(stcb_pkg::PRE_ASYNC_LO) * 16'({1'b0,
        baud_divisor_reg} + 9'h001))
    else $error("low speed bit time wrong");
  chk_hi_speed_gap: assert property ( // R6
    baud_tick && gap_ok_reg && !sync_mode && ctrl_reg.high_speed_baud_select
    |-> gap_cnt_reg == 16'(stcb_pkg::PRE_ASYNC_HI) * 16'({1'b0,
        baud_divisor_reg} + 9'h001))
    else $error("high speed bit time wrong");
  chk_sync_gap_fixed: assert property ( // R3
    baud_tick && gap_ok_reg && sync_mode
    |-> gap_cnt_reg == 16'(stcb_pkg::PRE_SYNC_HALF) * 16'({1'b0,
        baud_divisor_reg} + 9'h001))
    else $error("sync half period depends on speed bit");
  chk_clk_drive_mode: assert property ( // R1
    link_clk_oe_o |-> sync_mode && ctrl_reg.clock_source_select)
    else $error("link clock driven outside sync master");
  chk_async_idle_high: assert property ( // R2
    !busy |-> tx_o && !clk_out_reg)
    else $error("idle line not high");
  chk_ninth_bit_load: assert property ( // R4
    s_load_async9 |=> transmit_shift_register[9] == $past(ctrl_reg[0])
      && transmit_shift_register[0] == 1'b0)
    else $error("ninth bit not in frame");
  chk_enable_gates_tx: assert property ( // R9
    !ctrl_reg.transmitter_enable |=> !busy)
    else $error("shifting while transmitter disabled");
  chk_break_low_line: assert property ( // R10
    s_break_run |-> !tx_o)
    else $error("break line not low");
  chk_break_self_clear: assert property ( // R10
    break_done && !wr_tsc |=> !ctrl_reg.break_send_request
      && irq_stat_reg[stcb_pkg::IRQ_BREAK_DONE])
    else $error("break request not cleared");
  chk_empty_flag_load: assert property ( // R10
    load |=> !tsc_view[1] ##0 busy)
    else $error("empty flag still set after load");

endmodule

/* File: stcb_top_tb.sv */
// testbench for the serial transmit control block
// assumes stcb_top and stcb_link_partner are compiled alongside
module stcb_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] awa = 8'h00;
  logic [7:0] ara = 8'h00;
  logic [31:0] wd = 32'h00000000;
  logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic go = 1'b0, nine = 1'b0, quiet = 1'b0;
  logic awr, wrd, bv, arr, rv, tx, txoe, lco, lcoe, cre, ade, irq;
  logic plk, stp;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, v;
  logic [15:0] bl = 16'h0010;
  logic [8:0] rxd, ssh;
  logic [7:0] tsc, d;
  int rxc, lowl, bad_count = 0, checked = 0, seed = 49;
  logic [1:0] hs_t [4] = '{2'h1, 2'h0, 2'h1, 2'h1};
  logic [7:0] div_t [4] = '{8'h00, 8'h00, 8'h02, 8'h00};

  stcb_top stcb_top_inst (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .tx_o(tx), .tx_oe_o(txoe),
    .link_clk_i(plk), .link_clk_o(lco), .link_clk_oe_o(lcoe),
    .continuous_receive_enable_o(cre), .address_detect_enable_o(ade),
    .irq_o(irq));
  stcb_link_partner stcb_link_partner_inst (.core_clk_i(core_clk_i),
    .tx_i(tx), .bit_len_i(bl), .nine_i(nine), .clk_oe_i(lcoe),
    .clk_in_i(lco), .slave_go_i(go), .link_clk_o(plk), .rx_data_o(rxd),
    .stop_o(stp), .rx_count_o(rxc), .low_len_o(lowl), .sync_sh_o(ssh));

  initial forever #10 core_clk_i = ~core_clk_i;

  // ----------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dat,
                    input logic [1:0] re);
    int k;
    k = 0;
    @(posedge core_clk_i);
    awa <= a;
    wd <= dat;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge core_clk_i);
      if (awv && awr) awv <= 1'b0;
      if (wv && wrd) wv <= 1'b0;
      k++;
    end while (bv !== 1'b1 && k < 100);
    br <= 1'b0;
    chk(bv, 1'b1, "write answer");
    chk(bresp, re, "write response");
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input logic [1:0] re);
    int k;
    k = 0;
    @(posedge core_clk_i);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge core_clk_i);
      if (arv && arr) arv <= 1'b0;
      k++;
    end while (rv !== 1'b1 && k < 100);
    rr <= 1'b0;
    v = rdata;
    chk(rv, 1'b1, "read answer");
    chk(rresp, re, "read response");
    if (!quiet) chk(v, exp, "read data");
  endtask
  task automatic wait_empty();
    int k;
    k = 0;
    quiet = 1'b1;
    do begin
      rd(stcb_pkg::OFF_TSC, {24'h0, tsc | 8'h02}, stcb_pkg::RESP_OKAY);
      k++;
    end while (v[1] !== 1'b1 && k < 40);
    quiet = 1'b0;
    chk(v, {24'h0, tsc | 8'h02}, "shifter empty");
  endtask
  function automatic logic [15:0] bit_len(logic hs, logic [7:0] dv);
    return (hs ? 16'd16 : 16'd64) * (16'(dv) + 16'd1);
  endfunction

  initial begin
    #(20 * 40000);
    bad_count++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rd(stcb_pkg::OFF_TSC, 32'h02, stcb_pkg::RESP_OKAY);
    rd(stcb_pkg::OFF_DIV, 32'h00, stcb_pkg::RESP_OKAY);
    rd(stcb_pkg::OFF_IRQ_STAT, 32'h00, stcb_pkg::RESP_OKAY);
    rd(stcb_pkg::OFF_IRQ_CLR, 32'h00, stcb_pkg::RESP_SLVERR);
    rd(8'h1C, 32'h00, stcb_pkg::RESP_SLVERR);
    wr(8'h1C, 32'hFF, stcb_pkg::RESP_SLVERR);
    wr(stcb_pkg::OFF_TSC, 32'h00, stcb_pkg::RESP_OKAY);
    chk({tx, txoe, lcoe}, 3'b100, "idle pins");
    $display("reset values done");
    for (int c = 0; c < 4; c++) begin
      d = 8'($random(seed));
      nine = (c == 3);
      tsc = {1'b0, nine, 3'h4, hs_t[c][0], 1'b0, 1'($random(seed))};
      bl = bit_len(hs_t[c][0], div_t[c]);
      wr(stcb_pkg::OFF_DIV, {24'h0, div_t[c]}, stcb_pkg::RESP_OKAY);
      wr(stcb_pkg::OFF_TSC, {24'h0, tsc}, stcb_pkg::RESP_OKAY);
      wr(stcb_pkg::OFF_TXDATA, {24'h0, d}, stcb_pkg::RESP_OKAY);
      rd(stcb_pkg::OFF_TSC, {24'h0, tsc}, stcb_pkg::RESP_OKAY);
      for (int k = 0; k < 4000 && rxc == c; k++) @(posedge core_clk_i);
      chk({stp, rxd}, {1'b1, nine & tsc[0], d}, "async frame");
      wait_empty();
    end
    chk(irq, 1'b0, "masked irq");
    wr(stcb_pkg::OFF_IRQ_EN, 32'h03, stcb_pkg::RESP_OKAY);
    chk(irq, 1'b1, "enabled irq");
    wr(stcb_pkg::OFF_IRQ_CLR, 32'h01, stcb_pkg::RESP_OKAY);
    rd(stcb_pkg::OFF_IRQ_STAT, 32'h00, stcb_pkg::RESP_OKAY);
    chk(irq, 1'b0, "cleared irq");
    $display("async frames done");
    nine = 1'b0;
    bl = 16'd16;
    tsc = 8'h24;
    wr(stcb_pkg::OFF_TSC, 32'h2C, stcb_pkg::RESP_OKAY);
    wr(stcb_pkg::OFF_TXDATA, 32'h55, stcb_pkg::RESP_OKAY);
    for (int k = 0; k < 4000 && tx !== 1'b0; k++) @(posedge core_clk_i);
    for (int k = 0; k < 4000 && tx !== 1'b1; k++) @(posedge core_clk_i);
    repeat (2) @(posedge core_clk_i);
    chk(lowl, 13 * 16, "break length");
    wait_empty();
    chk(irq, 1'b1, "break irq");
    wr(stcb_pkg::OFF_IRQ_CLR, 32'h03, stcb_pkg::RESP_OKAY);
    $display("break done");
    tsc = 8'hB4;
    wr(stcb_pkg::OFF_TSC, {24'h0, tsc}, stcb_pkg::RESP_OKAY);
    chk({lcoe, txoe}, 2'b11, "master clock pin");
    d = 8'($random(seed));
    wr(stcb_pkg::OFF_TXDATA, {24'h0, d}, stcb_pkg::RESP_OKAY);
    wait_empty();
    chk(ssh[8:1], d, "sync master data");
    tsc = 8'h34;
    wr(stcb_pkg::OFF_TSC, {24'h0, tsc}, stcb_pkg::RESP_OKAY);
    chk(lcoe, 1'b0, "slave clock pin");
    d = 8'($random(seed));
    wr(stcb_pkg::OFF_TXDATA, {24'h0, d}, stcb_pkg::RESP_OKAY);
    go <= 1'b1;
    wait_empty();
    go <= 1'b0;
    chk(ssh[8:1], d, "sync slave data");
    wr(stcb_pkg::OFF_TSC, 32'hA4, stcb_pkg::RESP_OKAY);
    chk(lcoe, 1'b0, "async clock pin");
    $display("sync frames done");
    wr(stcb_pkg::OFF_RXCTL, 32'h03, stcb_pkg::RESP_OKAY);
    chk({cre, ade}, 2'b11, "receive enables");
    wr(stcb_pkg::OFF_RXCTL, 32'h02, stcb_pkg::RESP_OKAY);
    chk({cre, ade}, 2'b01, "receive recovery");
    wr(stcb_pkg::OFF_RXCTL, 32'h00, stcb_pkg::RESP_OKAY);
    chk({cre, ade}, 2'b00, "address detect off");
    $display("receive control done");
    stop_test();
  end
endmodule
